// File: line_protection_monitor.sv
// Line protection monitor: phase-loss and undervoltage trips with APB registers
// Functional notes
// - Phase-loss check has on/off setting; when on, lost phase trips with phase code.
// - Phases checked only during startup; losses while running are not flagged.
// - Line below threshold percent of nominal (default 70) trips with undervoltage code.
// - Undervoltage must persist for configured delay (default 5 s) before tripping.
// - Undervoltage supervision is inactive until a start signal arrives.
// - Immediate voltage collapse trips at once, skipping the delay.
// - Stop-only parameters accept writes only while stopped; ignored while running.
// - Advanced protection parameters reachable only with advanced mode on.
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module line_protection_monitor
    import lpm_pkg::*;
#(
    parameter logic [31:0] sec_count = lpm_pkg::sec_cycles,
    parameter logic [31:0] start_count = lpm_pkg::start_cycles,
    parameter int volt_width = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic run_cmd,
    input wire logic [2:0] phase_present,
    input wire logic [volt_width-1:0] line_voltage,
    output logic motor_on,
    output logic phase_fault_trip,
    output logic undervolt_trip,
    output logic irq
);
    import lpm_pkg::*;

    // =========================================
    // Input synchronisation
    logic run_s;
    logic [2:0] phase_s;

    // Pin inputs pass the three-stage filter
    lpm_sync #(.width(4)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in({run_cmd, phase_present}),
        .sync_out({run_s, phase_s})
    );

    // Line voltage comes from an on-chip converter on pclk, registered once
    logic [volt_width-1:0] volt_r;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            volt_r <= '0;
        end
        else
        begin
            volt_r <= line_voltage;
        end
    end

    // =========================================
    // Registers
    logic advanced_access_mode_r;
    logic phase_loss_check_enable_r;
    logic [6:0] uv_pct_r;
    logic [3:0] uv_delay_r;
    logic [volt_width-1:0] nominal_r;
    logic [1:0] irq_status_r;
    logic [1:0] irq_mask_r;
    logic [1:0] trip_code_r;
    logic trip_clear_r;
    starter_state_type state_r;
    starter_state_type state_nxt;

    logic wr_en;
    logic rd_en;
    logic stopped;
    logic set_phase;
    logic set_uv;
    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign stopped = (state_r == st_stopped) || (state_r == st_tripped);

    // Zero-wait APB: every access ends in its first access cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0);
        end
    end

    logic bad_addr;
    assign bad_addr = paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0;
    logic wr_go;
    assign wr_go = wr_en && pready && !bad_addr;

    // Control register: advanced mode always writable, phase check stop-only and only in advanced mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            advanced_access_mode_r <= 1'b0;
            phase_loss_check_enable_r <= phase_en_reset;
            trip_clear_r <= 1'b0;
        end
        else
        begin
            trip_clear_r <= 1'b0;
            if (wr_go && paddr == ctrl_off)
            begin
                advanced_access_mode_r <= pwdata[advanced_bit];
                trip_clear_r <= pwdata[trip_clear_bit];
                if (advanced_access_mode_r && stopped)
                begin
                    phase_loss_check_enable_r <= pwdata[phase_en_bit];
                end
            end
        end
    end

    // Protection parameters: advanced mode only; the threshold and delay are
    // changeable in run, the nominal level is stop-only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            uv_pct_r <= uv_pct_reset;
            uv_delay_r <= uv_delay_reset;
            nominal_r <= volt_width'(nominal_reset);
        end
        else if (wr_go && advanced_access_mode_r)
        begin
            // Out-of-range values are clamped rather than rejected
            if (paddr == uv_pct_off)
            begin
                if (pwdata[6:0] < uv_pct_min)
                    uv_pct_r <= uv_pct_min;
                else if (pwdata[6:0] > uv_pct_max || pwdata[31:7] != '0)
                    uv_pct_r <= uv_pct_max;
                else
                    uv_pct_r <= pwdata[6:0];
            end
            if (paddr == uv_delay_off)
            begin
                if (pwdata[3:0] < uv_delay_min)
                    uv_delay_r <= uv_delay_min;
                else if (pwdata[3:0] > uv_delay_max || pwdata[31:4] != '0)
                    uv_delay_r <= uv_delay_max;
                else
                    uv_delay_r <= pwdata[3:0];
            end
            if (paddr == nominal_off && stopped)
            begin
                nominal_r <= pwdata[volt_width-1:0];
            end
        end
    end

    // Read mux; advanced parameters read zero outside advanced mode
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            case (paddr)
                ctrl_off: prdata <= {29'h0, 1'b0, phase_loss_check_enable_r,
                    advanced_access_mode_r};
                uv_pct_off: prdata <= advanced_access_mode_r ? {25'h0, uv_pct_r} : 32'h0;
                uv_delay_off: prdata <= advanced_access_mode_r ? {28'h0, uv_delay_r} : 32'h0;
                nominal_off: prdata <= advanced_access_mode_r ?
                    32'(nominal_r) : 32'h0;
                status_off: prdata <= {30'h0, state_r};
                irq_status_off: prdata <= {30'h0, irq_status_r};
                irq_mask_off: prdata <= {30'h0, irq_mask_r};
                trip_code_off: prdata <= {30'h0, trip_code_r};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // =========================================
    // Threshold arithmetic
    logic [volt_width+6:0] volt_scaled;
    logic [volt_width+6:0] uv_level;
    logic [volt_width+6:0] collapse_level;
    logic below;
    logic collapsed;
    assign volt_scaled = (volt_width+7)'(volt_r) * (volt_width+7)'(100);
    assign uv_level = (volt_width+7)'(nominal_r) * (volt_width+7)'(uv_pct_r);
    assign collapse_level = (volt_width+7)'(nominal_r) * (volt_width+7)'(collapse_pct);
    assign below = volt_scaled < uv_level;
    assign collapsed = volt_scaled < collapse_level;

    // =========================================
    // Starter sequence
    logic [31:0] start_cnt_r;
    logic start_done;
    logic phase_lost;
    logic uv_expired;
    assign start_done = start_cnt_r >= start_count;
    assign phase_lost = phase_loss_check_enable_r && phase_s != 3'b111;

    // Next state; trips win over other moves
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            st_stopped:
                // The controller closes the contactor before run
                if (run_s)
                    state_nxt = st_starting;
            st_starting:
                if (phase_lost)
                    state_nxt = st_tripped;
                else if (!run_s)
                    state_nxt = st_stopped;
                else if (start_done)
                    state_nxt = st_running;
            st_running:
                if (collapsed || uv_expired)
                    state_nxt = st_tripped;
                else if (!run_s)
                    state_nxt = st_stopped;
            st_tripped:
                if (trip_clear_r && !run_s)
                    state_nxt = st_stopped;
            default:
                state_nxt = st_stopped;
        endcase
        // Undervoltage also watched while starting, after the start signal
        if (state_r == st_starting && (collapsed || uv_expired))
            state_nxt = st_tripped;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_r <= st_stopped;
        else
            state_r <= state_nxt;
    end

    // Startup window timer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            start_cnt_r <= 32'h0;
        else if (state_r == st_starting && !start_done)
            start_cnt_r <= start_cnt_r + 32'h1;
        else if (state_r != st_starting)
            start_cnt_r <= 32'h0;
    end

    // =========================================
    // Undervoltage delay timer
    logic [31:0] sec_cnt_r;
    logic [3:0] uv_sec_r;
    logic uv_active;
    assign uv_active = state_r == st_starting || state_r == st_running;
    assign uv_expired = uv_sec_r >= uv_delay_r;

    // Seconds prescaler and elapsed seconds of low voltage
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sec_cnt_r <= 32'h0;
            uv_sec_r <= 4'h0;
        end
        else if (!uv_active || !below)
        begin
            sec_cnt_r <= 32'h0;
            uv_sec_r <= 4'h0;
        end
        else if (sec_cnt_r >= sec_count - 32'h1)
        begin
            sec_cnt_r <= 32'h0;
            if (!uv_expired)
                uv_sec_r <= uv_sec_r + 4'h1;
        end
        else
        begin
            sec_cnt_r <= sec_cnt_r + 32'h1;
        end
    end

    // =========================================
    // Trip reporting and outputs
    assign set_phase = state_r == st_starting && phase_lost;
    assign set_uv = uv_active && (collapsed || uv_expired) && !set_phase;

    // Trip code holds the first cause until cleared
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trip_code_r <= code_none;
            phase_fault_trip <= 1'b0;
            undervolt_trip <= 1'b0;
        end
        else if (set_phase)
        begin
            trip_code_r <= code_phase;
            phase_fault_trip <= 1'b1;
        end
        else if (set_uv)
        begin
            trip_code_r <= code_undervolt;
            undervolt_trip <= 1'b1;
        end
        else if (state_r == st_tripped && state_nxt == st_stopped)
        begin
            trip_code_r <= code_none;
            phase_fault_trip <= 1'b0;
            undervolt_trip <= 1'b0;
        end
    end

    // Sticky events: set wins over write-one-to-clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_status_r <= 2'h0;
            irq_mask_r <= 2'h0;
        end
        else
        begin
            if (wr_go && paddr == irq_mask_off)
                irq_mask_r <= pwdata[1:0];
            irq_status_r <= (irq_status_r & ~((wr_go && paddr == irq_status_off) ?
                pwdata[1:0] : 2'h0)) | {set_uv, set_phase};
        end
    end

    // Registered outputs
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq <= 1'b0;
            motor_on <= 1'b0;
        end
        else
        begin
            irq <= |(irq_status_r & irq_mask_r);
            motor_on <= state_nxt == st_starting || state_nxt == st_running;
        end
    end
endmodule
`default_nettype wire

// File: lpm_pkg.sv
// Package: register map, reset values and timing constants of the line protection monitor
package lpm_pkg;
    // APB register byte offsets
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] uv_pct_off = 8'h04;
    localparam logic [7:0] uv_delay_off = 8'h08;
    localparam logic [7:0] nominal_off = 8'h0c;
    localparam logic [7:0] status_off = 8'h10;
    localparam logic [7:0] irq_status_off = 8'h14;
    localparam logic [7:0] irq_mask_off = 8'h18;
    localparam logic [7:0] trip_code_off = 8'h1c;
    // Control field positions
    localparam int advanced_bit = 0;
    localparam int phase_en_bit = 1;
    localparam int trip_clear_bit = 2;
    // Reset values and write clamp limits
    localparam logic [6:0] uv_pct_reset = 7'h46;
    localparam logic [3:0] uv_delay_reset = 4'h5;
    localparam logic [6:0] uv_pct_min = 7'h32;
    localparam logic [6:0] uv_pct_max = 7'h5a;
    localparam logic [3:0] uv_delay_min = 4'h1;
    localparam logic [3:0] uv_delay_max = 4'ha;
    localparam logic [11:0] nominal_reset = 12'hfff;
    localparam logic phase_en_reset = 1'b1;
    // Collapse level in percent of nominal
    localparam logic [6:0] collapse_pct = 7'h0a;
    // Trip codes
    localparam logic [1:0] code_none = 2'h0;
    localparam logic [1:0] code_phase = 2'h1;
    localparam logic [1:0] code_undervolt = 2'h2;
    // Timing: one second at 250 MHz
    localparam int clk_mhz = 250;
    localparam int sec_ms = 1000;
    localparam longint sec_cycles_l = longint'(clk_mhz) * 1000 * 1000 * sec_ms / 1000;
    localparam logic [31:0] sec_cycles = 32'(sec_cycles_l);
    // Startup window during which phases are checked
    localparam int start_ms = 200;
    localparam logic [31:0] start_cycles = 32'(longint'(clk_mhz) * 1000 * start_ms);
    // Starter states
    typedef enum logic [1:0] {
        st_stopped = 2'b00,
        st_starting = 2'b01,
        st_running = 2'b11,
        st_tripped = 2'b10
    } starter_state_type;
endpackage

// File: lpm_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module lpm_sync #(
    parameter int width = 1
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [width-1:0] async_in,
    output logic [width-1:0] sync_out
);
    logic [width-1:0] s1_r;
    logic [width-1:0] s2_r;
    logic [width-1:0] s3_r;

    // =========================================
    // Capture chain; a change counts when stages two and three agree
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            sync_out <= '0;
        end
        else
        begin
            s1_r <= async_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < width; i++)
            begin
                if (s2_r[i] == s3_r[i])
                begin
                    sync_out[i] <= s3_r[i];
                end
            end
        end
    end
endmodule
`default_nettype wire

// File: lpm_properties.sv
// Port-level checker for the line protection monitor
`timescale 1ns/1ps
`default_nettype none
module lpm_properties #(
    parameter logic [31:0] sec_count = 32'd20,
    parameter logic [31:0] start_count = 32'd10,
    parameter int volt_width = 12
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic run_cmd,
    input wire logic [2:0] phase_present,
    input wire logic [volt_width-1:0] line_voltage,
    input wire logic motor_on,
    input wire logic phase_fault_trip,
    input wire logic undervolt_trip,
    input wire logic irq
);
    // Default threshold: 70 % of a full-scale nominal; only valid while it is unchanged
    localparam int thr = 2867;
    // Default undervoltage delay in seconds; same caveat as the threshold
    localparam int delay_s = 5;
    logic [31:0] on_cnt_r;
    logic [31:0] low_cnt_r;
    // Cycles since start and cycles spent below threshold
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            on_cnt_r <= 32'h0;
            low_cnt_r <= 32'h0;
        end
        else
        begin
            on_cnt_r <= motor_on ? on_cnt_r + 32'h1 : 32'h0;
            low_cnt_r <= (line_voltage < thr) ? low_cnt_r + 32'h1 : 32'h0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // Bus answer
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_answer;
        pready ##1 !pready;
    endsequence
    property p_answer;
        s_setup |=> s_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("ready not a one-cycle answer");
    property p_refuse;
        psel && !penable && paddr >= 8'h20 |=> pslverr;
    endproperty
    a_refuse: assert property (p_refuse) else $error("unmapped access not refused");
    // ==========================================
    // Protection
    property p_start;
        $rose(motor_on) |-> run_cmd;
    endproperty
    a_start: assert property (p_start) else $error("start without run command");
    property p_uv_armed;
        $rose(undervolt_trip) |-> $past(motor_on);
    endproperty
    a_uv_armed: assert property (p_uv_armed) else $error("undervolt trip while stopped");
    property p_collapse;
        (motor_on && line_voltage < 400) [*2] |-> ##[0:4] undervolt_trip;
    endproperty
    a_collapse: assert property (p_collapse) else $error("collapse not tripped at once");
    property p_uv_delay;
        $rose(undervolt_trip) |-> $past(line_voltage) < 410 || low_cnt_r >= sec_count * delay_s;
    endproperty
    a_uv_delay: assert property (p_uv_delay) else $error("undervolt trip too early");
    property p_phase_window;
        $rose(phase_fault_trip) |-> on_cnt_r <= start_count + 8;
    endproperty
    a_phase_window: assert property (p_phase_window) else $error("phase trip after startup");
    property p_off;
        phase_fault_trip || undervolt_trip |-> !motor_on;
    endproperty
    a_off: assert property (p_off) else $error("motor on while tripped");
    property p_hold;
        $fell(undervolt_trip || phase_fault_trip) |-> $past(psel && pwrite) || $past(psel && pwrite, 2);
    endproperty
    a_hold: assert property (p_hold) else $error("trip released without clear");
endmodule
bind line_protection_monitor lpm_properties #(
    .sec_count(sec_count),
    .start_count(start_count),
    .volt_width(volt_width)
) props (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_cmd(run_cmd), .phase_present(phase_present), .line_voltage(line_voltage),
    .motor_on(motor_on), .phase_fault_trip(phase_fault_trip),
    .undervolt_trip(undervolt_trip), .irq(irq)
);
`default_nettype wire

// File: lpm_supply.sv
// Run command source with a downstream contactor
`timescale 1ns/1ps
`default_nettype none
module lpm_supply (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic want_run,
    input wire logic [2:0] phase_loss,
    output logic run_cmd,
    output logic contactor_closed,
    output logic [2:0] phase_present
);
    // Contactor closes before the run command and opens only after it drops
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            contactor_closed <= 1'b0;
            run_cmd <= 1'b0;
        end
        else
        begin
            contactor_closed <= want_run || run_cmd;
            run_cmd <= want_run && contactor_closed;
        end
    end
    // Lost phases read as absent
    assign phase_present = ~phase_loss;
endmodule
`default_nettype wire

// File: test_line_protection_monitor.sv
// Self-checking bench for the line protection monitor
`timescale 1ns/1ps
`default_nettype none
module test_line_protection_monitor;
    import lpm_pkg::*;
    typedef struct {logic [7:0] a; logic w; logic [31:0] d; logic [31:0] e; logic err;} row_type;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic run_cmd, motor_on, phase_fault_trip, undervolt_trip, irq, contactor, want_run = 0, e;
    logic [2:0] phase_present, phase_loss = 3'h0;
    logic [11:0] line_voltage = 12'hbb8;
    int errors = 0, check_count = 0, cyc = 0, c;
    // Short second (20 cycles) and startup (10 cycles) keep the run brief
    line_protection_monitor #(.sec_count(32'd20), .start_count(32'd10), .volt_width(12)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .run_cmd(run_cmd), .phase_present(phase_present), .line_voltage(line_voltage),
        .motor_on(motor_on), .phase_fault_trip(phase_fault_trip),
        .undervolt_trip(undervolt_trip), .irq(irq));
    lpm_supply far (.pclk(pclk), .presetn(presetn), .want_run(want_run),
        .phase_loss(phase_loss), .run_cmd(run_cmd), .contactor_closed(contactor),
        .phase_present(phase_present));
    row_type rows [9] = '{
        '{nominal_off, 1'b0, 32'h0, 32'h0, 1'b0},
        '{uv_pct_off, 1'b1, 32'h50, 32'h0, 1'b0},
        '{ctrl_off, 1'b1, 32'h3, 32'h0, 1'b0},
        '{uv_pct_off, 1'b0, 32'h0, 32'h46, 1'b0},
        '{uv_delay_off, 1'b0, 32'h0, 32'h5, 1'b0},
        '{nominal_off, 1'b0, 32'h0, 32'hfff, 1'b0},
        '{irq_mask_off, 1'b1, 32'h3, 32'h0, 1'b0},
        '{status_off, 1'b0, 32'h0, 32'h0, 1'b0},
        '{8'h20, 1'b0, 32'h0, 32'h0, 1'b1}};
    always #2 pclk = ~pclk;
    // ==========================================
    // Bus and check tasks
    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] x);
        apb(a, 1'b0, 32'h0);
        chk(r, x);
    endtask
    task clk(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task until_trip(input int n, output int k);
        k = 0;
        while (phase_fault_trip !== 1'b1 && undervolt_trip !== 1'b1 && k < n)
        begin
            @(posedge pclk);
            k++;
        end
    endtask
    // Stop, acknowledge the interrupt, then clear the trip
    task clear_trip;
        want_run <= 1'b0;
        clk(8);
        apb(irq_status_off, 1'b1, 32'h3);
        apb(ctrl_off, 1'b1, 32'h7);
        clk(4);
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Hang guard well above the expected run length
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            errors++;
            $display("timeout at %0t", $time);
            finish_test;
        end
    end
    // ==========================================
    // Main sequence
    initial
    begin
        clk(6);
        chk({motor_on, phase_fault_trip, undervolt_trip, irq, pready}, 32'h0);
        presetn <= 1'b1;
        $display("reset test done");
        foreach (rows[i])
        begin
            apb(rows[i].a, rows[i].w, rows[i].d);
            if (!rows[i].w)
                chk(r, rows[i].e);
            chk(e, rows[i].err);
        end
        $display("register table done");
        line_voltage <= 12'haf0;
        clk(150);
        chk(undervolt_trip, 0);
        want_run <= 1'b1;
        line_voltage <= 12'hbb8;
        clk(40);
        chk(motor_on, 1);
        chk(contactor, 1);
        apb(nominal_off, 1'b1, 32'h800);
        rd(nominal_off, 32'hfff);
        phase_loss <= 3'h1;
        clk(30);
        chk(phase_fault_trip, 0);
        phase_loss <= 3'h0;
        line_voltage <= 12'haf0;
        clk(60);
        line_voltage <= 12'hbb8;
        clk(5);
        line_voltage <= 12'haf0;
        clk(60);
        chk(undervolt_trip, 0);
        line_voltage <= 12'hbb8;
        clk(5);
        line_voltage <= 12'haf0;
        until_trip(200, c);
        chk(c >= 80 && c <= 112, 1);
        rd(trip_code_off, code_undervolt);
        chk(irq, 1);
        rd(irq_status_off, 32'h2);
        line_voltage <= 12'hbb8;
        clear_trip;
        chk({undervolt_trip, irq}, 0);
        $display("undervoltage delay test done");
        want_run <= 1'b1;
        clk(40);
        line_voltage <= 12'h064;
        until_trip(50, c);
        chk({c <= 6, undervolt_trip}, 3);
        line_voltage <= 12'hbb8;
        clear_trip;
        $display("collapse test done");
        phase_loss <= 3'h2;
        want_run <= 1'b1;
        until_trip(60, c);
        chk(phase_fault_trip, 1);
        rd(trip_code_off, code_phase);
        phase_loss <= 3'h0;
        clear_trip;
        apb(ctrl_off, 1'b1, 32'h1);
        phase_loss <= 3'h4;
        want_run <= 1'b1;
        clk(40);
        chk({phase_fault_trip, motor_on}, 1);
        apb(ctrl_off, 1'b1, 32'h3);
        rd(ctrl_off, 32'h1);
        $display("phase loss test done");
        // Reset in mid-run: outputs drop at once, defaults return
        want_run <= 1'b0;
        presetn <= 1'b0;
        clk(2);
        chk({motor_on, phase_fault_trip, undervolt_trip, irq, pready}, 32'h0);
        presetn <= 1'b1;
        rd(ctrl_off, 32'h2);
        $display("mid-run reset test done");
        finish_test;
    end
endmodule
`default_nettype wire
